// file: wcg_pkg.sv
// Behaviour
// - Gate bit one clocks the watchdog; zero leaves it unclocked and disabled.
// - Any access to the watchdog while its clock is gated gives a bus fault.
// - All gating bits of all three registers are zero after reset.
// - In run mode the watchdog enable comes from the run register.
// - In sleep mode the watchdog enable comes from the sleep register.
// - In deep sleep the watchdog enable comes from the deep-sleep register.
// - Sleep and deep-sleep registers apply only with automatic gating selected.
// - Bit 3 of each gating register is read/write, resets to zero.
// - All other bits are reserved: read as zero, writes ignored.
package wcg_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W         = 12;
  localparam logic [11:0] OFS_RUN_GATE   = 12'h100;
  localparam logic [11:0] OFS_SLEEP_GATE = 12'h110;
  localparam logic [11:0] OFS_DEEP_GATE  = 12'h120;
  localparam logic [11:0] OFS_IRQ_STAT   = 12'h130;
  localparam logic [11:0] OFS_IRQ_CLR    = 12'h134;
  localparam logic [11:0] OFS_IRQ_EN     = 12'h138;
  localparam logic [11:0] OFS_FAULT_CNT  = 12'h13C;
  localparam logic [11:0] OFS_STATE      = 12'h140;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int          WDG_BIT        = 3;
  localparam logic        GATE_RST       = 1'b0;
  localparam logic [31:0] ZERO_WORD      = 32'h0000_0000;
  localparam int          IRQ_W          = 3;
  localparam int          IRQ_FAULT      = 0;
  localparam int          IRQ_CLK_ON     = 1;
  localparam int          IRQ_CLK_OFF    = 2;
  localparam logic [2:0]  IRQ_RST        = 3'h0;
  localparam int          ST_CLK_EN      = 0;
  localparam int          ST_AUTO        = 1;
  localparam int          ST_MODE_LO     = 4;
  localparam int          FCNT_W         = 8;
  localparam logic [7:0]  FCNT_RST       = 8'h00;
  localparam logic [7:0]  FCNT_MAX       = 8'hFF;
  localparam logic [7:0]  FCNT_ONE       = 8'h01;

  // ----------------------------------------------------------------
  // Power modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_SLEEP,
    MODE_DEEP
  } wcg_mode_t;

  function automatic logic wcg_gate_bit(input logic [31:0] word);
    wcg_gate_bit = word[WDG_BIT];
  endfunction : wcg_gate_bit

endpackage : wcg_pkg

// file: wcg_enable_sel.sv
`timescale 1ns/1ns
`default_nettype none
module wcg_enable_sel
  import wcg_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rst,
  input  wire wcg_mode_t mode,
  input  wire logic      auto_gate,
  input  wire logic      run_bit,
  input  wire logic      sleep_bit,
  input  wire logic      deep_bit,
  output logic           clk_en
);

  // ----------------------------------------------------------------
  // Source selection
  // ----------------------------------------------------------------
  wire logic use_sleep;
  wire logic use_deep;
  wire logic en_nxt;

  assign use_sleep = auto_gate && (mode == MODE_SLEEP);
  assign use_deep  = auto_gate && (mode == MODE_DEEP);
  // Run register otherwise, in every mode when automatic gating is off
  assign en_nxt    = use_deep  ? deep_bit  :
                     use_sleep ? sleep_bit :
                                 run_bit;

  // ----------------------------------------------------------------
  // Registered enable: one clean edge per change, no decode glitches
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
      clk_en <= GATE_RST;
    else
      clk_en <= en_nxt;
  end

endmodule : wcg_enable_sel
`default_nettype wire

// file: wcg_top.sv
// The plain strobed port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module wcg_top
  import wcg_pkg::*;
#(
  parameter int FAULT_CNT_W = FCNT_W
)
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  input  wire logic              automatic_gating_select,
  input  wire logic              sleep_now,
  input  wire logic              deep_sleep_now,
  input  wire logic              wdg_req,
  input  wire logic              wdg_req_write,
  output logic                   wdg_req_pass,
  output logic                   bus_fault,
  output logic                   watchdog_clk_en,
  output logic                   irq
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic                   run_gate_r;
  logic                   sleep_gate_r;
  logic                   deep_gate_r;
  logic [IRQ_W-1:0]       irq_stat_r;
  logic [IRQ_W-1:0]       irq_stat_nxt;
  logic [IRQ_W-1:0]       irq_en_r;
  logic [FAULT_CNT_W-1:0] fault_cnt_r;
  logic [FAULT_CNT_W-1:0] fault_cnt_nxt;
  logic [31:0]            rdata_r;
  logic [31:0]            rdata_nxt;
  logic                   pass_r;
  logic                   fault_r;
  logic                   irq_r;
  logic                   clk_en_prev_r;
  wcg_mode_t              mode_r;
  wcg_mode_t              mode_nxt;
  logic                   clk_en;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire logic hit_run;
  wire logic hit_sleep;
  wire logic hit_deep;
  wire logic hit_stat;
  wire logic hit_clr;
  wire logic hit_en;
  wire logic hit_fcnt;
  wire logic hit_state;
  wire logic wr_run;
  wire logic wr_sleep;
  wire logic wr_deep;
  wire logic wr_clr;
  wire logic wr_en;
  wire logic wr_fcnt;

  assign hit_run   = (reg_addr == OFS_RUN_GATE);
  assign hit_sleep = (reg_addr == OFS_SLEEP_GATE);
  assign hit_deep  = (reg_addr == OFS_DEEP_GATE);
  assign hit_stat  = (reg_addr == OFS_IRQ_STAT);
  assign hit_clr   = (reg_addr == OFS_IRQ_CLR);
  assign hit_en    = (reg_addr == OFS_IRQ_EN);
  assign hit_fcnt  = (reg_addr == OFS_FAULT_CNT);
  assign hit_state = (reg_addr == OFS_STATE);

  assign wr_run    = reg_wr && hit_run;
  assign wr_sleep  = reg_wr && hit_sleep;
  assign wr_deep   = reg_wr && hit_deep;
  assign wr_clr    = reg_wr && hit_clr;
  assign wr_en     = reg_wr && hit_en;
  assign wr_fcnt   = reg_wr && hit_fcnt;

  // ----------------------------------------------------------------
  // Gating registers
  // ----------------------------------------------------------------
  // Only the watchdog bit is stored; reserved bits have no storage
  wire logic run_gate_nxt;
  wire logic sleep_gate_nxt;
  wire logic deep_gate_nxt;

  assign run_gate_nxt   = wr_run   ? wcg_gate_bit(reg_wdata) : run_gate_r;
  assign sleep_gate_nxt = wr_sleep ? wcg_gate_bit(reg_wdata) : sleep_gate_r;
  assign deep_gate_nxt  = wr_deep  ? wcg_gate_bit(reg_wdata) : deep_gate_r;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      run_gate_r   <= GATE_RST;
      sleep_gate_r <= GATE_RST;
      deep_gate_r  <= GATE_RST;
    end
    else
    begin
      run_gate_r   <= run_gate_nxt;
      sleep_gate_r <= sleep_gate_nxt;
      deep_gate_r  <= deep_gate_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Power mode tracking
  // ----------------------------------------------------------------
  // Deep sleep takes priority when both requests stand
  always_comb
  begin
    mode_nxt = mode_r;
    case (mode_r)
      MODE_RUN:
      begin
        if (deep_sleep_now)
          mode_nxt = MODE_DEEP;
        else if (sleep_now)
          mode_nxt = MODE_SLEEP;
      end
      MODE_SLEEP:
      begin
        if (deep_sleep_now)
          mode_nxt = MODE_DEEP;
        else if (!sleep_now)
          mode_nxt = MODE_RUN;
      end
      MODE_DEEP:
      begin
        if (!deep_sleep_now)
          mode_nxt = sleep_now ? MODE_SLEEP : MODE_RUN;
      end
      default:
        mode_nxt = MODE_RUN;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      mode_r <= MODE_RUN;
    else
      mode_r <= mode_nxt;
  end

  // ----------------------------------------------------------------
  // Watchdog clock enable
  // ----------------------------------------------------------------
  wcg_enable_sel u_sel (
    .clk       (clk),
    .rst       (rst),
    .mode      (mode_r),
    .auto_gate (automatic_gating_select),
    .run_bit   (run_gate_r),
    .sleep_bit (sleep_gate_r),
    .deep_bit  (deep_gate_r),
    .clk_en    (clk_en)
  );

  assign watchdog_clk_en = clk_en;

  // ----------------------------------------------------------------
  // Watchdog access gate
  // ----------------------------------------------------------------
  wire logic fault_ev;
  wire logic pass_ev;
  wire logic clk_on_ev;
  wire logic clk_off_ev;

  assign pass_ev    = wdg_req && clk_en;
  assign fault_ev   = wdg_req && !clk_en;
  assign clk_on_ev  = clk_en && !clk_en_prev_r;
  assign clk_off_ev = !clk_en && clk_en_prev_r;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pass_r        <= 1'b0;
      fault_r       <= 1'b0;
      clk_en_prev_r <= GATE_RST;
    end
    else
    begin
      pass_r        <= pass_ev;
      fault_r       <= fault_ev;
      clk_en_prev_r <= clk_en;
    end
  end

  assign wdg_req_pass = pass_r;
  assign bus_fault    = fault_r;

  // ----------------------------------------------------------------
  // Fault counter
  // ----------------------------------------------------------------
  // Saturates; any write clears it, a fault in the same cycle counts
  wire logic fcnt_full;
  wire logic fcnt_inc;

  assign fcnt_full     = (fault_cnt_r == FAULT_CNT_W'(FCNT_MAX));
  assign fcnt_inc      = fault_ev && !fcnt_full;
  assign fault_cnt_nxt = wr_fcnt ?
                         (fault_ev ? FAULT_CNT_W'(FCNT_ONE) : FAULT_CNT_W'(FCNT_RST)) :
                         (fcnt_inc ?
                          fault_cnt_r + FAULT_CNT_W'(FCNT_ONE) : fault_cnt_r);

  always_ff @(posedge clk)
  begin
    if (rst)
      fault_cnt_r <= FAULT_CNT_W'(FCNT_RST);
    else
      fault_cnt_r <= fault_cnt_nxt;
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  wire logic [IRQ_W-1:0] irq_set;
  wire logic [IRQ_W-1:0] irq_clr;
  wire logic [IRQ_W-1:0] wdata_irq;
  wire logic [IRQ_W-1:0] irq_en_nxt;
  wire logic             irq_nxt;

  assign wdata_irq    = reg_wdata[IRQ_W-1:0];
  assign irq_set      = {clk_off_ev, clk_on_ev, fault_ev};
  assign irq_clr      = wr_clr ? wdata_irq : IRQ_RST;
  // A new event wins over a clear in the same cycle
  assign irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_set;
  assign irq_en_nxt   = wr_en ? wdata_irq : irq_en_r;
  // Level output follows the status and enable stored at the same edge
  assign irq_nxt      = |(irq_stat_nxt & irq_en_nxt);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      irq_stat_r <= IRQ_RST;
      irq_en_r   <= IRQ_RST;
      irq_r      <= 1'b0;
    end
    else
    begin
      irq_stat_r <= irq_stat_nxt;
      irq_en_r   <= irq_en_nxt;
      irq_r      <= irq_nxt;
    end
  end

  assign irq = irq_r;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Places a stored gate bit in its field; reserved bits stay zero
  function automatic logic [31:0] gate_word(input logic bit_val);
    gate_word = 32'(bit_val) << WDG_BIT;
  endfunction : gate_word

  wire logic [31:0] rd_run;
  wire logic [31:0] rd_sleep;
  wire logic [31:0] rd_deep;
  wire logic [31:0] rd_stat;
  wire logic [31:0] rd_en;
  wire logic [31:0] rd_fcnt;
  wire logic [31:0] rd_state;

  // Reserved bits read as zero
  assign rd_run   = gate_word(run_gate_r);
  assign rd_sleep = gate_word(sleep_gate_r);
  assign rd_deep  = gate_word(deep_gate_r);
  assign rd_stat  = 32'(irq_stat_r);
  assign rd_en    = 32'(irq_en_r);
  assign rd_fcnt  = 32'(fault_cnt_r);
  assign rd_state = (32'(clk_en) << ST_CLK_EN)
                  | (32'(automatic_gating_select) << ST_AUTO)
                  | (32'(mode_r) << ST_MODE_LO);

  // Write-only clear register and unmapped offsets read zero
  assign rdata_nxt = !reg_rd   ? ZERO_WORD :
                     hit_run   ? rd_run    :
                     hit_sleep ? rd_sleep  :
                     hit_deep  ? rd_deep   :
                     hit_stat  ? rd_stat   :
                     hit_en    ? rd_en     :
                     hit_fcnt  ? rd_fcnt   :
                     hit_state ? rd_state  :
                                 ZERO_WORD;

  always_ff @(posedge clk)
  begin
    if (rst)
      rdata_r <= ZERO_WORD;
    else
      rdata_r <= rdata_nxt;
  end

  assign reg_rdata = rdata_r;

endmodule : wcg_top
`default_nettype wire

// file: wcg_top_sva.sv
`timescale 1ns/1ns
`default_nettype none
module wcg_top_sva
  import wcg_pkg::*;
#(
  parameter int FAULT_CNT_W = FCNT_W
)
(
  input wire logic              clk,
  input wire logic              rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0]       reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [31:0]       reg_rdata,
  input wire logic              automatic_gating_select,
  input wire logic              sleep_now,
  input wire logic              deep_sleep_now,
  input wire logic              wdg_req,
  input wire logic              wdg_req_write,
  input wire logic              wdg_req_pass,
  input wire logic              bus_fault,
  input wire logic              watchdog_clk_en,
  input wire logic              irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire gate_rd = reg_rd && (reg_addr == OFS_RUN_GATE || reg_addr == OFS_SLEEP_GATE
                 || reg_addr == OFS_DEEP_GATE);
  wire auto_n  = !automatic_gating_select;

  chk_fault_gated: assert property (
    wdg_req && !watchdog_clk_en |=> bus_fault && !wdg_req_pass)
    else $error("gated access not faulted");
  chk_pass_clocked: assert property (
    wdg_req && watchdog_clk_en |=> wdg_req_pass && !bus_fault)
    else $error("clocked access not passed");
  chk_no_stray: assert property (
    !wdg_req |=> !bus_fault && !wdg_req_pass)
    else $error("response without request");
  chk_rdata_idle: assert property (
    !reg_rd |=> reg_rdata == ZERO_WORD)
    else $error("read data outside read slot");
  chk_reserved_zero: assert property (
    gate_rd |=> reg_rdata[31:4] == 28'h0 && reg_rdata[2:0] == 3'h0)
    else $error("reserved gate bits not zero");
  chk_run_write: assert property (
    reg_wr && reg_addr == OFS_RUN_GATE && auto_n ##1 auto_n
    |=> watchdog_clk_en == $past(reg_wdata[WDG_BIT], 2))
    else $error("run gate write not applied");
  chk_reset_quiet: assert property (
    $fell(rst) |-> !watchdog_clk_en && !irq && !bus_fault)
    else $error("outputs active after reset");
  chk_auto_steady: assert property (
    (auto_n && !reg_wr) [*4] |-> $stable(watchdog_clk_en))
    else $error("enable moved without cause");
endmodule : wcg_top_sva

bind wcg_top wcg_top_sva #(.FAULT_CNT_W(FAULT_CNT_W)) u_sva (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .automatic_gating_select(automatic_gating_select), .sleep_now(sleep_now),
  .deep_sleep_now(deep_sleep_now), .wdg_req(wdg_req), .wdg_req_write(wdg_req_write),
  .wdg_req_pass(wdg_req_pass), .bus_fault(bus_fault),
  .watchdog_clk_en(watchdog_clk_en), .irq(irq));
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import wcg_pkg::*;
;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = 12'h000;
  logic [31:0]       reg_wdata = 32'h0;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic              auto_sel = 1'b0;
  logic              sleep_now = 1'b0;
  logic              deep_now = 1'b0;
  logic              wdg_req = 1'b0;
  logic              wdg_wr = 1'b0;
  logic [31:0]       reg_rdata;
  logic              pass;
  logic              bus_fault;
  logic              clk_en;
  logic              irq;
  logic [31:0]       seed = 32'h4A;
  logic [31:0]       d;
  logic [31:0]       v;
  logic [2:0]        g;
  logic              e;
  int                mismatches = 0;
  int                cmp_count = 0;
  logic [11:0]       gofs [3] = '{OFS_RUN_GATE, OFS_SLEEP_GATE, OFS_DEEP_GATE};

  always #4 clk = ~clk;

  wcg_top #(.FAULT_CNT_W(8)) dut (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .automatic_gating_select(auto_sel), .sleep_now(sleep_now),
    .deep_sleep_now(deep_now), .wdg_req(wdg_req), .wdg_req_write(wdg_wr),
    .wdg_req_pass(pass), .bus_fault(bus_fault), .watchdog_clk_en(clk_en), .irq(irq));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Deep sleep wins; without automatic gating the run bit rules
  function automatic logic exp_en(input logic a, input logic s, input logic dp,
                                  input logic [2:0] gb);
    if (!a || (!s && !dp))
      return gb[0];
    return dp ? gb[2] : gb[1];
  endfunction : exp_en

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] x);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= x;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic acc(input logic flt);
    @(posedge clk);
    v = rnd();
    wdg_req <= 1'b1;
    wdg_wr <= v[0];
    @(posedge clk);
    wdg_req <= 1'b0;
    #1 chk(bus_fault, flt);
    chk(pass, !flt);
  endtask : acc

  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask : settle

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize

  initial
  begin
    repeat (6000) @(posedge clk);
    mismatches++;
    summarize();
  end

  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    #1 chk(clk_en, 0);
    foreach (gofs[i])
    begin
      rd(gofs[i]);
      chk(d, 0);
    end
    acc(1'b1);
    rd(OFS_FAULT_CNT);
    chk(d, 32'h1);
    $display("test reset done");
    repeat (12)
    begin
      g = 3'(rnd() % 3);
      v = rnd();
      wr(gofs[g], v);
      rd(gofs[g]);
      chk(d, v & 32'h8);
    end
    wr(12'h200, rnd());
    rd(12'h200);
    chk(d, 0);
    rd(OFS_SLEEP_GATE);
    wr(OFS_SLEEP_GATE, d | 32'h8);
    rd(OFS_SLEEP_GATE);
    chk(d, 32'h8);
    $display("test registers done");
    for (int k = 0; k < 12; k++)
    begin
      v = rnd();
      g = v[6:4];
      foreach (gofs[i])
        wr(gofs[i], {v[31:4] ^ 28'(i), g[i], v[2:0]});
      @(posedge clk);
      auto_sel <= k[0];
      sleep_now <= (k / 2) % 3 != 0;
      deep_now <= (k / 2) % 3 == 2;
      e = exp_en(k[0], (k / 2) % 3 != 0, (k / 2) % 3 == 2, g);
      settle();
      chk(clk_en, e);
      acc(!e);
    end
    @(posedge clk);
    auto_sel <= 1'b0;
    wr(OFS_RUN_GATE, 32'h0);
    settle();
    $display("test modes done");
    wr(OFS_IRQ_CLR, 32'h7);
    wr(OFS_IRQ_EN, 32'h1);
    #1 chk(irq, 0);
    acc(1'b1);
    chk(irq, 1);
    rd(OFS_IRQ_STAT);
    chk(d[0], 1);
    wr(OFS_IRQ_CLR, 32'h1);
    @(posedge clk);
    #1 chk(irq, 0);
    wr(OFS_IRQ_EN, 32'h0);
    acc(1'b1);
    chk(irq, 0);
    rd(OFS_IRQ_STAT);
    chk(d[0], 1);
    wr(OFS_FAULT_CNT, rnd());
    rd(OFS_FAULT_CNT);
    chk(d, 0);
    repeat (256) acc(1'b1);
    rd(OFS_FAULT_CNT);
    chk(d, 32'(FCNT_MAX));
    $display("test interrupts done");
    wr(OFS_RUN_GATE, 32'h8);
    settle();
    chk(clk_en, 1);
    acc(1'b0);
    rd(OFS_IRQ_STAT);
    chk(d[IRQ_CLK_ON], 1);
    rd(OFS_STATE);
    chk(d, (32'h1 << ST_CLK_EN) | (32'(MODE_DEEP) << ST_MODE_LO));
    wr(OFS_IRQ_CLR, 32'h7);
    wr(OFS_RUN_GATE, 32'h0);
    settle();
    rd(OFS_IRQ_STAT);
    chk(d, 32'h1 << IRQ_CLK_OFF);
    wr(OFS_RUN_GATE, 32'h8);
    settle();
    chk(clk_en, 1);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1 chk(clk_en, 0);
    rd(OFS_RUN_GATE);
    chk(d, 0);
    $display("test second reset done");
    summarize();
  end
endmodule : tb_top
`default_nettype wire
